// ---- common/cfgsl_pkg.sv ----
// Constants shared by the strap latch block
//
// Notes on behaviour
// - Strap pins float during any reset.
// - Capture strap levels at reset release; the code samples after SETTLE_CYCLES settle cycles.
// - Power-on or external reset re-latches all straps.
// - Internal pulls define unconnected strap level.
// - Fixed-port code also sets indicator polarity.
// - Local power detect: fixed ports from register.
// - High charge strap enables port charging.
// - Lines disabled only when both straps high.
// - Method from select straps and data pin.
package cfgsl_pkg;

  localparam int NSTRAP = 10;

  // Strap vector field positions
  localparam int FPS_LSB  = 0;
  localparam int CSEL_LSB = 2;
  localparam int CHG_LSB  = 4;
  localparam int MDIS_LSB = 6;
  localparam int PDIS_LSB = 8;

  // Register byte offsets
  localparam logic [11:0] ADDR_STAT = 12'h000;
  localparam logic [11:0] ADDR_DEC  = 12'h004;
  localparam logic [11:0] ADDR_CTRL = 12'h008;
  localparam logic [11:0] ADDR_OUT  = 12'h00c;

  // Status register fields
  localparam int STAT_SDA_BIT   = 10;
  localparam int STAT_STATE_LSB = 11;
  localparam int STAT_VALID_BIT = 13;

  // Decode register fields
  localparam int DEC_FIX_LSB  = 0;
  localparam int DEC_POL_BIT  = 2;
  localparam int DEC_CHG_LSB  = 3;
  localparam int DEC_DIS_LSB  = 5;
  localparam int DEC_METH_LSB = 7;

  // Control register fields
  localparam int CTRL_SUSP_BIT = 0;
  localparam int CTRL_FIX_LSB  = 1;

  // Reset values and AHB encodings
  localparam logic [2:0]        CTRL_RST       = 3'h0;
  localparam logic [NSTRAP-1:0] OUT_RST        = 10'h000;
  localparam logic [NSTRAP-1:0] STRAP_PULL_RST = 10'h000;
  localparam logic [1:0]        HTRANS_NONSEQ  = 2'h2;
  localparam logic [2:0]        HSIZE_WORD     = 3'h2;

  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int SETTLE_NS     = 1000;
  localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    METH_SELF,
    METH_BUS,
    METH_EEPROM,
    METH_SMBUS,
    METH_INVALID
  } cfgsl_method_e;

  typedef enum logic [1:0] {
    ST_HOLD,
    ST_SETTLE,
    ST_LATCH,
    ST_RUN
  } cfgsl_state_e;

endpackage

// ---- logic/cfgsl_sync.sv ----
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module cfgsl_sync #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta <= RST_VAL;
      q    <= RST_VAL;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// ---- logic/cfgsl_decode.sv ----
// Decode of latched strap levels into hub defaults
`timescale 1ns/10ps
module cfgsl_decode
  import cfgsl_pkg::*;
(
  input  wire logic [NSTRAP-1:0] straps,
  input  wire logic              sda,
  input  wire logic              local_power_detect,
  input  wire logic [1:0]        fixed_override,
  output logic      [1:0]        fixed_port_select,
  output logic                   susp_active_low,
  output logic      [1:0]        port_charge_enable,
  output logic      [1:0]        port_line_disable,
  output cfgsl_method_e          method
);
  wire [1:0] fps_code = straps[FPS_LSB +: 2];
  wire [1:0] sel_code = straps[CSEL_LSB +: 2];
  // Bit 0 is port 1, bit 1 is port 2
  wire [1:0] fps_dec  = (fps_code == 2'h0) ? 2'h0 :
                        (fps_code == 2'h1) ? 2'h1 : 2'h3;

  assign susp_active_low    = fps_code[0];
  assign fixed_port_select  = local_power_detect ? fixed_override : fps_dec;
  assign port_charge_enable = straps[CHG_LSB +: 2];
  assign port_line_disable  = straps[MDIS_LSB +: 2] & straps[PDIS_LSB +: 2];

  always_comb begin
    case (sel_code)
      2'h0:    method = METH_SELF;
      2'h2:    method = METH_BUS;
      2'h3:    method = sda ? METH_EEPROM : METH_INVALID;
      2'h1:    method = sda ? METH_SMBUS : METH_INVALID;
      default: method = METH_INVALID;
    endcase
  end
endmodule

// ---- logic/cfgsl_strap_latch.sv ----
// Strap latch: captures strap pins after reset, decodes defaults, AHB-Lite registers
`timescale 1ns/10ps
module cfgsl_strap_latch
  import cfgsl_pkg::*;
#(
  parameter int                SETTLE_CYCLES = SETTLE_CYC,
  parameter logic [NSTRAP-1:0] STRAP_PULL    = STRAP_PULL_RST
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              por_n,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic      [31:0]       hrdata,
  input  wire logic [NSTRAP-1:0] strap_in,
  output logic      [NSTRAP-1:0] strap_out,
  output logic      [NSTRAP-1:0] strap_oe,
  output logic      [NSTRAP-1:0] strap_pull_up,
  input  wire logic              sda_in,
  input  wire logic              local_power_detect,
  output logic                   straps_valid,
  output logic      [1:0]        fixed_port_select,
  output logic                   suspend_indicator_low,
  output logic      [1:0]        port_charge_enable,
  output logic      [1:0]        port_line_disable,
  output logic      [2:0]        config_method
);
  localparam int CW = $clog2(SETTLE_CYCLES + 1);
  localparam logic [CW-1:0] SETTLE_LAST = CW'(SETTLE_CYCLES - 1);

  if (SETTLE_CYCLES < 1) begin : g_chk
    $error("SETTLE_CYCLES must be at least one");
  end

  // Synchronised pins
  logic [NSTRAP-1:0] strap_s;
  logic              sda_s;
  logic              lpd_s;
  logic              por_q;

  cfgsl_sync #(.W(NSTRAP), .RST_VAL(STRAP_PULL)) u_sync_strap (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       (strap_in),
    .q       (strap_s)
  );

  cfgsl_sync #(.W(3), .RST_VAL(3'h0)) u_sync_misc (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       ({por_n, sda_in, local_power_detect}),
    .q       ({por_q, sda_s, lpd_s})
  );

  // Capture sequencer
  cfgsl_state_e      state;
  cfgsl_state_e      next_state;
  logic [CW-1:0]     settle_cnt;
  logic [NSTRAP-1:0] latched;
  logic              sda_latched;

  wire settle_done = (settle_cnt == SETTLE_LAST);

  always_comb begin
    next_state = state;
    case (state)
      ST_HOLD:   next_state = ST_SETTLE;
      // Pins must reach their level before sampling
      ST_SETTLE: next_state = settle_done ? ST_LATCH : ST_SETTLE;
      ST_LATCH:  next_state = ST_RUN;
      ST_RUN:    next_state = ST_RUN;
      default:   next_state = ST_HOLD;
    endcase
    // Power-on reset restarts the whole capture
    if (!por_q) begin
      next_state = ST_HOLD;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_HOLD;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      settle_cnt <= '0;
    end else if (state == ST_SETTLE) begin
      settle_cnt <= settle_cnt + CW'(1);
    end else begin
      settle_cnt <= '0;
    end
  end

  // Only the latch state writes; later pin activity is ignored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latched     <= STRAP_PULL;
      sda_latched <= 1'b0;
    end else if (state == ST_LATCH) begin
      latched     <= strap_s;
      sda_latched <= sda_s;
    end
  end

  // Register file
  logic              susp_req;
  logic [1:0]        fix_override;
  logic [NSTRAP-1:0] out_data;

  logic [1:0]    dec_fixed;
  logic          dec_pol;
  logic [1:0]    dec_chg;
  logic [1:0]    dec_dis;
  cfgsl_method_e dec_meth;

  cfgsl_decode u_decode (
    .straps             (latched),
    .sda                (sda_latched),
    .local_power_detect (lpd_s),
    .fixed_override     (fix_override),
    .fixed_port_select  (dec_fixed),
    .susp_active_low    (dec_pol),
    .port_charge_enable (dec_chg),
    .port_line_disable  (dec_dis),
    .method             (dec_meth)
  );

  wire run       = (state == ST_RUN);
  wire valid_now = run;

  // Outputs from flops; pins released only in normal operation
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_oe      <= '0;
      strap_out     <= OUT_RST;
      strap_pull_up <= STRAP_PULL;
    end else begin
      strap_oe      <= (run && por_q) ? {NSTRAP{1'b1}} : '0;
      strap_out     <= {out_data[NSTRAP-1:1], susp_req ^ dec_pol};
      strap_pull_up <= STRAP_PULL;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      straps_valid          <= 1'b0;
      fixed_port_select     <= 2'h0;
      suspend_indicator_low <= 1'b0;
      port_charge_enable    <= 2'h0;
      port_line_disable     <= 2'h0;
      config_method         <= 3'h0;
    end else begin
      straps_valid          <= valid_now;
      fixed_port_select     <= dec_fixed;
      suspend_indicator_low <= dec_pol;
      port_charge_enable    <= dec_chg;
      port_line_disable     <= dec_dis;
      config_method         <= dec_meth;
    end
  end

  // AHB-Lite slave, zero wait states
  wire        acc    = hsel && (htrans == HTRANS_NONSEQ) && hready;
  wire [11:0] a_off  = haddr[11:0];
  wire        a_top  = (haddr[31:12] == 20'h00000);
  wire        word   = (hsize == HSIZE_WORD);

  logic        wr_pend;
  logic [11:0] wr_off;

  wire wr_ctrl = wr_pend && (wr_off == ADDR_CTRL);
  wire wr_out  = wr_pend && (wr_off == ADDR_OUT);

  wire [31:0] stat_word = {18'h0, valid_now, 2'(state), sda_latched, latched};
  wire [31:0] dec_word  = {22'h0, 3'(dec_meth), dec_dis, dec_chg, dec_pol, dec_fixed};
  wire [31:0] ctrl_word = {29'h0, fix_override, susp_req};
  wire [31:0] out_word  = {22'h0, out_data};

  wire [31:0] rd_mux = !a_top                 ? 32'h0 :
                       (a_off == ADDR_STAT) ? stat_word :
                       (a_off == ADDR_DEC)  ? dec_word :
                       (a_off == ADDR_CTRL) ? ctrl_word :
                       (a_off == ADDR_OUT)  ? out_word : 32'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_off  <= 12'h000;
    end else begin
      wr_pend <= acc && hwrite && word && a_top;
      wr_off  <= a_off;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hrdata    <= (acc && !hwrite) ? rd_mux : 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      susp_req     <= CTRL_RST[CTRL_SUSP_BIT];
      fix_override <= CTRL_RST[CTRL_FIX_LSB +: 2];
      out_data     <= OUT_RST;
    end else begin
      if (wr_ctrl) begin
        susp_req     <= hwdata[CTRL_SUSP_BIT];
        fix_override <= hwdata[CTRL_FIX_LSB +: 2];
      end
      if (wr_out) begin
        out_data <= hwdata[NSTRAP-1:0];
      end
    end
  end

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_oe_float_por: assert property (!por_q |=> strap_oe == '0)
    else $error("strap pins driven during reset");

  a_oe_not_run: assert property (state != ST_RUN |=> strap_oe == '0)
    else $error("strap pins driven before capture");

  a_capture_level: assert property (state == ST_LATCH |=> latched == $past(strap_s))
    else $error("latched straps differ from pins");

  a_por_hold: assert property (!por_q |=> state == ST_HOLD)
    else $error("capture not held during power-on reset");

  // Reset may last many cycles; the restart is checked at its release
  a_por_restart: assert property (!por_q ##1 por_q |-> state == ST_HOLD ##1 state == ST_SETTLE)
    else $error("power-on reset did not restart capture");

  a_pull_const: assert property (strap_pull_up == STRAP_PULL)
    else $error("strap pull setting changed");

  a_fixed_code3: assert property (run && !lpd_s && latched[1:0] == 2'h3
                                  |=> fixed_port_select == 2'h3 && suspend_indicator_low)
    else $error("fixed port code 3 decoded wrongly");

  a_fixed_code1: assert property (run && !lpd_s && latched[1:0] == 2'h1
                                  |=> fixed_port_select == 2'h1 && suspend_indicator_low)
    else $error("fixed port code 1 decoded wrongly");

  a_local_power: assert property (lpd_s |=> fixed_port_select == $past(fix_override))
    else $error("override ignored under local power");

  a_charge_en: assert property (run |=> port_charge_enable == $past(latched[5:4]))
    else $error("charge enable differs from strap");

  a_line_dis: assert property (run |=> port_line_disable == ($past(latched[7:6]) & $past(latched[9:8])))
    else $error("line disable not both straps");

  a_bad_method: assert property (run && latched[3:2] == 2'h1 && !sda_latched
                                 |=> config_method == 3'(METH_INVALID))
    else $error("invalid method not flagged");

  a_hold_latched: assert property (run && por_q |=> $stable(latched) && $stable(sda_latched))
    else $error("latched straps changed in operation");

  a_settle_time: assert property ($rose(state == ST_SETTLE) |-> (state == ST_SETTLE) [*8])
    else $error("settle period cut short");

  c_capture:   cover property (state == ST_LATCH ##1 run);
  c_por_rerun: cover property (run && !por_q);
  c_local_power_detect: cover property (run && lpd_s);
  c_invalid:   cover property (run && config_method == 3'(METH_INVALID));
endmodule

// ---- verification/cfgsl_board.sv ----
// Board side of the strap pins: fitted resistors, else internal pulls, resolve each undriven pin level
`timescale 1ns/10ps
module cfgsl_board
  import cfgsl_pkg::*;
(
  input  wire logic [NSTRAP-1:0] strap_out,
  input  wire logic [NSTRAP-1:0] strap_oe,
  input  wire logic [NSTRAP-1:0] strap_pull_up,
  input  wire logic [NSTRAP-1:0] ext_fit,
  input  wire logic [NSTRAP-1:0] ext_up,
  output logic      [NSTRAP-1:0] strap_in
);
  wire logic [NSTRAP-1:0] float_lvl;
  // External resistor beats the weak internal one; board never drives
  assign float_lvl = (ext_fit & ext_up) | (~ext_fit & strap_pull_up);
  assign strap_in  = (strap_oe & strap_out) | (~strap_oe & float_lvl);
endmodule

// ---- verification/config_strap_latch_test.sv ----
// Self-checking bench for the strap latch
`timescale 1ns/10ps
module config_strap_latch_test
  import cfgsl_pkg::*;
;
  logic              hclk;
  logic              hresetn;
  logic              por_n;
  logic              hsel;
  logic [31:0]       haddr;
  logic [1:0]        htrans;
  logic              hwrite;
  logic [2:0]        hsize;
  logic [31:0]       hwdata;
  wire logic         hready;
  logic              hreadyout;
  logic              hresp;
  logic [31:0]       hrdata;
  logic [NSTRAP-1:0] strap_in;
  logic [NSTRAP-1:0] strap_out;
  logic [NSTRAP-1:0] strap_oe;
  logic [NSTRAP-1:0] strap_pull_up;
  logic [NSTRAP-1:0] ext_fit;
  logic [NSTRAP-1:0] ext_up;
  logic              sda_in;
  logic              local_power_detect;
  logic              straps_valid;
  logic [1:0]        fixed_port_select;
  logic              suspend_indicator_low;
  logic [1:0]        port_charge_enable;
  logic [1:0]        port_line_disable;
  logic [2:0]        config_method;
  int                fails;
  int                compares;
  int                cyc = 0;

  assign hready = hreadyout;

  cfgsl_strap_latch #(.SETTLE_CYCLES(8)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .por_n(por_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .strap_in(strap_in),
    .strap_out(strap_out), .strap_oe(strap_oe), .strap_pull_up(strap_pull_up),
    .sda_in(sda_in), .local_power_detect(local_power_detect), .straps_valid(straps_valid),
    .fixed_port_select(fixed_port_select), .suspend_indicator_low(suspend_indicator_low),
    .port_charge_enable(port_charge_enable), .port_line_disable(port_line_disable),
    .config_method(config_method)
  );

  cfgsl_board board_u (
    .strap_out(strap_out), .strap_oe(strap_oe), .strap_pull_up(strap_pull_up),
    .ext_fit(ext_fit), .ext_up(ext_up), .strap_in(strap_in)
  );

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  task print_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      print_verdict;
    end
  end

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Single word transfer; waits on hready, data taken at data phase end
  task ahb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {20'h00000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize  <= HSIZE_WORD;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    chk("hresp", '0, 32'(hresp));
  endtask

  function automatic logic [31:0] dec_exp(input logic [9:0] s, input logic d);
    logic [2:0] m;
    case (s[3:2])
      2'h0:    m = 3'h0;
      2'h2:    m = 3'h1;
      2'h3:    m = d ? 3'h2 : 3'h4;
      default: m = d ? 3'h3 : 3'h4;
    endcase
    return {22'h0, m, s[7:6] & s[9:8], s[5:4], s[0], s[1], s[1] | s[0]};
  endfunction

  task do_reset(input logic by_por);
    int n;
    if (by_por)
      por_n <= 1'b0;
    else
      hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    chk("strap_oe in reset", '0, 32'(strap_oe));
    hresetn <= 1'b1;
    por_n   <= 1'b1;
    n = 0;
    while (straps_valid !== 1'b1 && n < 200) begin
      @(posedge hclk);
      n++;
    end
    repeat (3) @(posedge hclk);
    chk("straps_valid", 32'h1, 32'(straps_valid));
    chk("strap_pull_up", 32'(STRAP_PULL_RST), 32'(strap_pull_up));
  endtask

  logic [9:0]  s;
  logic [9:0]  exp_s;
  logic [9:0]  o;
  logic [1:0]  ov;
  logic        d;
  logic        sp;
  logic [2:0]  ctrl_exp;
  logic [31:0] rd;

  initial begin
    hresetn = 1'b0;
    por_n = 1'b1;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = '0;
    ext_fit = '0;
    ext_up = '0;
    sda_in = 1'b0;
    local_power_detect = 1'b0;
    fails = 0;
    compares = 0;
    ctrl_exp = CTRL_RST;
    void'($urandom(39300));
    for (int i = 0; i < 12; i++) begin
      s = 10'($urandom);
      s[3:2] = i[1:0];
      // First pass leaves pins unconnected: internal pulls decide
      ext_fit <= (i == 0) ? '0 : '1;
      ext_up <= s;
      sda_in <= i[2];
      local_power_detect <= 1'b0;
      do_reset(i[0]);
      exp_s = (i == 0) ? STRAP_PULL_RST : s;
      d = (i == 0) ? 1'b0 : i[2];
      chk("strap_oe", 32'h3ff, 32'(strap_oe));
      chk("decode", dec_exp(exp_s, d), {22'h0, config_method, port_line_disable,
          port_charge_enable, suspend_indicator_low, fixed_port_select});
      ahb(1'b0, ADDR_STAT, '0, rd);
      chk("stat", {18'h0, 1'b1, 2'h3, d, exp_s}, rd);
      ahb(1'b0, ADDR_DEC, '0, rd);
      chk("dec reg", dec_exp(exp_s, d), rd);
      // Only the external reset clears the control register
      if (!i[0])
        ctrl_exp = CTRL_RST;
      ahb(1'b0, ADDR_CTRL, '0, rd);
      chk("ctrl after reset", 32'(ctrl_exp), rd);
      // Pins now driven and board flipped: latched values must not move
      ext_up <= ~s;
      o = 10'($urandom);
      ahb(1'b1, ADDR_OUT, {22'h0, o}, rd);
      ahb(1'b1, ADDR_STAT, 32'hffffffff, rd);
      ahb(1'b0, ADDR_OUT, '0, rd);
      chk("out reg", {22'h0, o}, rd);
      chk("strap_out", 32'(o[9:1]), 32'(strap_out[9:1]));
      ahb(1'b0, ADDR_STAT, '0, rd);
      chk("stat held", {18'h0, 1'b1, 2'h3, d, exp_s}, rd);
      ahb(1'b0, 12'h010, '0, rd);
      chk("unmapped", '0, rd);
      ov = 2'($urandom);
      sp = 1'($urandom);
      ctrl_exp = {ov, sp};
      ahb(1'b1, ADDR_CTRL, {29'h0, ctrl_exp}, rd);
      ahb(1'b0, ADDR_CTRL, '0, rd);
      chk("ctrl reg", 32'(ctrl_exp), rd);
      local_power_detect <= 1'b1;
      repeat (5) @(posedge hclk);
      chk("fixed override", 32'(ov), 32'(fixed_port_select));
      chk("suspend pin", 32'(sp ^ exp_s[0]), 32'(strap_out[0]));
      chk("decode held", dec_exp(exp_s, d) & 32'h3fc, {22'h0, config_method,
          port_line_disable, port_charge_enable, suspend_indicator_low, 2'h0});
      $display("test %0d done", i);
    end
    print_verdict;
  end
endmodule
